// [hdl/osc_trim_unlock.sv]
// Oscillator tune sequence, trim value, guarded control and start-up group
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "osc_trim_defines.svh"

// Summary of operation
// - Roll index 111 trims the oscillator from tune field 7, bits 15-12.
// - Roll index 110 trims the oscillator from tune field 6, bits 11-8.
// - Roll index 101 trims the oscillator from tune field 5, bits 7-4.
// - Roll index 100 trims the oscillator from tune field 4, bits 3-0.
// - Fifteen-bit trim value register, read and write; bit 15 reads zero.
// - After both keys, a byte write is taken only in the next cycle.
// - At reset the two-bit group field picks the initial oscillator group.
// - Select configuration word bits 23 down to 2 read as zero.
module osc_trim_unlock #(
    parameter logic [15:0] CTRL_RESET = `RST_CTRL
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [23:0] rd_data_o,
    // Oscillator side
    input wire logic [2:0] pwm_roll_i,
    input wire logic [1:0] group_strap_i,
    output logic [3:0] frc_trim_o,
    output logic [14:0] trim_value_o,
    output logic [15:0] osc_ctrl_o,
    output logic [1:0] osc_group_o
);

    osc_trim_pkg::bus_req_t req;
    logic [15:0] tune_seq;
    logic [14:0] trim_value;
    logic [3:0] base_trim;
    logic [15:0] osc_ctrl;
    logic [1:0] group_cfg;
    logic [3:0] next_trim;
    logic [23:0] next_rd;

    assign req = '{addr: addr_i, wdata: wr_data_i, wr: wr_i, rd: rd_i};

    function automatic logic [3:0] select_trim(
        input logic [2:0] roll,
        input logic [15:0] seq,
        input logic [3:0] base
    );
        logic [3:0] pick;
        case (roll)
            `ROLL_SEQ7: pick = seq[15:12];
            `ROLL_SEQ6: pick = seq[11:8];
            `ROLL_SEQ5: pick = seq[7:4];
            `ROLL_SEQ4: pick = seq[3:0];
            default: pick = base;
        endcase
        return pick;
    endfunction

    // Write decode
    wire logic wr_seq = req.wr && (req.addr == `ADDR_TUNE_SEQ);
    wire logic wr_trim = req.wr && (req.addr == `ADDR_TRIM_VALUE);
    wire logic wr_base = req.wr && (req.addr == `ADDR_BASE_TRIM);
    wire logic wr_lo = req.wr && (req.addr == `ADDR_CTRL_LO);
    wire logic wr_hi = req.wr && (req.addr == `ADDR_CTRL_HI);
    wire logic lo_accept;
    wire logic hi_accept;
    wire logic lo_armed;
    wire logic hi_armed;

    unlock_guard #(
        .KEY1(`KEY_LO_FIRST),
        .KEY2(`KEY_LO_SECOND)
    ) lo_guard (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .wr_en_i(wr_lo),
        .wr_byte_i(req.wdata[7:0]),
        .accept_o(lo_accept),
        .armed_o(lo_armed)
    );

    unlock_guard #(
        .KEY1(`KEY_HI_FIRST),
        .KEY2(`KEY_HI_SECOND)
    ) hi_guard (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .wr_en_i(wr_hi),
        .wr_byte_i(req.wdata[7:0]),
        .accept_o(hi_accept),
        .armed_o(hi_armed)
    );

    // Tune field select by roll index
    // The four lower roll codes keep the base trim field
    assign next_trim = select_trim(pwm_roll_i, tune_seq, base_trim);

    always_comb begin
        next_rd = 24'h000000;
        if (req.rd) begin
            case (req.addr)
                `ADDR_TUNE_SEQ: next_rd = {8'h00, tune_seq};
                `ADDR_TRIM_VALUE: next_rd = {9'h000, trim_value};
                `ADDR_CTRL_LO: next_rd = {8'h00, osc_ctrl};
                `ADDR_BASE_TRIM: next_rd = {20'h00000, base_trim};
                `ADDR_SELECT_CFG: next_rd = {22'h000000, group_cfg};
                `ADDR_STATUS: next_rd = {18'h00000, hi_armed, lo_armed,
                                         frc_trim_o};
                default: next_rd = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tune_seq <= `RST_TUNE_SEQ;
            trim_value <= `RST_TRIM_VALUE;
            base_trim <= `RST_BASE_TRIM;
        end else begin
            if (wr_seq) begin
                tune_seq <= req.wdata;
            end
            if (wr_trim) begin
                trim_value <= req.wdata[14:0];
            end
            if (wr_base) begin
                base_trim <= req.wdata[3:0];
            end
        end
    end

    // Guarded byte updates
    // Key bytes themselves never land in the control register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            osc_ctrl <= CTRL_RESET;
        end else begin
            if (lo_accept) begin
                osc_ctrl[7:0] <= req.wdata[7:0];
            end
            if (hi_accept) begin
                osc_ctrl[15:8] <= req.wdata[7:0];
            end
        end
    end

    // Group caught while reset is held
    // The strap is sampled on every clock edge while reset is held, so the last one before release counts
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            group_cfg <= group_strap_i;
        end
    end

    // Outputs straight from flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_data_o <= 24'h000000;
            frc_trim_o <= `RST_BASE_TRIM;
            trim_value_o <= `RST_TRIM_VALUE;
            osc_ctrl_o <= CTRL_RESET;
            osc_group_o <= group_strap_i;
        end else begin
            rd_data_o <= next_rd;
            frc_trim_o <= next_trim;
            trim_value_o <= trim_value;
            osc_ctrl_o <= osc_ctrl;
            osc_group_o <= group_cfg;
        end
    end

    chk_roll_seven_sel: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        pwm_roll_i == 3'h7 |=> frc_trim_o == $past(tune_seq[15:12]))
        else $error("roll 111 did not select field 7");

    chk_roll_six_sel: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        pwm_roll_i == 3'h6 |=> frc_trim_o == $past(tune_seq[11:8]))
        else $error("roll 110 did not select field 6");

    chk_roll_five_sel: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        pwm_roll_i == 3'h5 |=> frc_trim_o == $past(tune_seq[7:4]))
        else $error("roll 101 did not select field 5");

    chk_roll_four_sel: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        pwm_roll_i == 3'h4 |=> frc_trim_o == $past(tune_seq[3:0]))
        else $error("roll 100 did not select field 4");

    chk_trim_write_read: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        wr_trim ##1 (rd_i && addr_i == `ADDR_TRIM_VALUE && !wr_i)
        |=> rd_data_o == {9'h000, $past(wr_data_i[14:0], 2)})
        else $error("trim value readback wrong or bit 15 set");

    chk_cfg_upper_zero: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        rd_i && addr_i == `ADDR_SELECT_CFG
        |=> rd_data_o[23:2] == 22'h000000)
        else $error("select configuration upper bits not zero");

    chk_group_from_strap: assert property (@(posedge sys_clk_i)
        srst_i ##1 !srst_i |-> osc_group_o == $past(group_strap_i, 1)
        ##1 osc_group_o == $past(osc_group_o))
        else $error("initial group not taken from strap");

    chk_ctrl_lo_guarded: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        osc_ctrl[7:0] != $past(osc_ctrl[7:0]) |-> $past(lo_accept))
        else $error("control low byte changed without unlock");

    chk_ctrl_hi_guarded: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        osc_ctrl[15:8] != $past(osc_ctrl[15:8]) |-> $past(hi_accept))
        else $error("control high byte changed without unlock");

endmodule

// [hdl/unlock_guard.sv]
// Two-key unlock guard for one byte of the oscillator control register
`timescale 1ns/100ps
module unlock_guard #(
    parameter logic [7:0] KEY1 = 8'h00,
    parameter logic [7:0] KEY2 = 8'h00
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Byte write to the guarded byte
    input wire logic wr_en_i,
    input wire logic [7:0] wr_byte_i,
    // Guard result
    output logic accept_o,
    output logic armed_o
);

    osc_trim_pkg::guard_state_t state;
    osc_trim_pkg::guard_state_t next_state;

    wire logic is_key1 = wr_en_i && (wr_byte_i == KEY1);
    wire logic is_key2 = wr_en_i && (wr_byte_i == KEY2);

    assign accept_o = (state == osc_trim_pkg::G_OPEN) && wr_en_i;
    assign armed_o = (state == osc_trim_pkg::G_OPEN);

    // Broken sequence re-arms
    // Any cycle without the second key breaks it unless it repeats the first key, as no gap is allowed
    always_comb begin
        next_state = osc_trim_pkg::G_IDLE;
        case (state)
            osc_trim_pkg::G_IDLE: begin
                if (is_key1) begin
                    next_state = osc_trim_pkg::G_KEY1;
                end
            end
            osc_trim_pkg::G_KEY1: begin
                if (is_key2) begin
                    next_state = osc_trim_pkg::G_OPEN;
                end else if (is_key1) begin
                    next_state = osc_trim_pkg::G_KEY1;
                end
            end
            osc_trim_pkg::G_OPEN: begin
                next_state = osc_trim_pkg::G_IDLE;
            end
            default: begin
                next_state = osc_trim_pkg::G_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= osc_trim_pkg::G_IDLE;
        end else begin
            state <= next_state;
        end
    end

    chk_open_one_cycle: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        state == osc_trim_pkg::G_OPEN |=> state == osc_trim_pkg::G_IDLE)
        else $error("guard stayed open beyond one cycle");

    chk_open_after_keys: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        state == osc_trim_pkg::G_OPEN
        |-> $past(is_key2, 1) && $past(is_key1, 2))
        else $error("guard opened without both keys in order");

endmodule

// [include/osc_trim_defines.svh]
// Offsets, field positions, keys and reset values of the trim block
`ifndef OSC_TRIM_DEFINES_SVH
`define OSC_TRIM_DEFINES_SVH

`define ADDR_TUNE_SEQ 8'h00
`define ADDR_TRIM_VALUE 8'h04
`define ADDR_CTRL_LO 8'h08
`define ADDR_CTRL_HI 8'h09
`define ADDR_BASE_TRIM 8'h0c
`define ADDR_SELECT_CFG 8'h10
`define ADDR_STATUS 8'h14

`define RST_TUNE_SEQ 16'h0000
`define RST_TRIM_VALUE 15'h0000
`define RST_BASE_TRIM 4'h0
`define RST_CTRL 16'h0000

`define KEY_LO_FIRST 8'h46
`define KEY_LO_SECOND 8'h57
`define KEY_HI_FIRST 8'h78
`define KEY_HI_SECOND 8'h9a

`define ROLL_SEQ7 3'h7
`define ROLL_SEQ6 3'h6
`define ROLL_SEQ5 3'h5
`define ROLL_SEQ4 3'h4

`define GROUP_FRC 2'h0
`define GROUP_FRC_PLL 2'h1
`define GROUP_PRIMARY 2'h2
`define GROUP_PRIMARY_PLL 2'h3

`endif

// [include/osc_trim_pkg.sv]
// Types shared by the trim and unlock logic
package osc_trim_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [2:0] {
        G_IDLE = 3'b001,
        G_KEY1 = 3'b010,
        G_OPEN = 3'b100
    } guard_state_t;

endpackage

// [verif/testbench.sv]
// Self-checking bench for the oscillator trim and unlock block
`timescale 1ns/100ps
`include "osc_trim_defines.svh"
module testbench;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [2:0] pwm_roll_i = 3'h0;
    logic [1:0] group_strap_i = 2'h0;
    logic [23:0] rd_data_o;
    logic [3:0] frc_trim_o;
    logic [14:0] trim_value_o;
    logic [15:0] osc_ctrl_o;
    logic [1:0] osc_group_o;
    logic [31:0] seed = 32'h0a0c1169;
    int fails = 0;
    int samples_checked = 0;
    int m_tseq, m_trim, m_base, m_ctrl;

    osc_trim_unlock dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .pwm_roll_i(pwm_roll_i),
        .group_strap_i(group_strap_i), .frc_trim_o(frc_trim_o),
        .trim_value_o(trim_value_o), .osc_ctrl_o(osc_ctrl_o),
        .osc_group_o(osc_group_o)
    );

    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [15:0] rnd();
        for (int i = 0; i < 16; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed[15:0];
    endfunction

    // Tune field picked by the roll index, else the base trim
    function automatic int exp_trim(input int roll);
        if (roll >= 4) begin
            return (m_tseq >> (4 * (roll - 4))) & 15;
        end
        return m_base & 15;
    endfunction

    task automatic compare(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic check_port(input logic [23:0] got, input int exp);
        compare(got, exp[23:0]);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wr_data_i <= d;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask

    task automatic check_read(input logic [7:0] a, input int exp);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 compare(rd_data_o, exp[23:0]);
    endtask

    task automatic do_reset(input logic [1:0] strap);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        group_strap_i <= strap;
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        m_tseq = 0;
        m_trim = 0;
        m_base = 0;
        m_ctrl = 0;
    endtask

    // Key pair, optional gaps, then the byte; a gap must lose the write
    task automatic unlock(input bit hi, input logic [7:0] k1,
                          input logic [7:0] k2, input int g1, input int g2,
                          input logic [7:0] v);
        logic [7:0] a;
        a = hi ? `ADDR_CTRL_HI : `ADDR_CTRL_LO;
        wr(a, {8'h00, k1});
        idle(g1);
        wr(a, {8'h00, k2});
        idle(g2);
        wr(a, {8'h00, v});
        idle(3);
        if (g1 == 0 && g2 == 0 &&
            k1 == (hi ? `KEY_HI_FIRST : `KEY_LO_FIRST) &&
            k2 == (hi ? `KEY_HI_SECOND : `KEY_LO_SECOND)) begin
            if (hi) begin
                m_ctrl = (m_ctrl & 'hff) | (v << 8);
            end else begin
                m_ctrl = (m_ctrl & 'hff00) | v;
            end
        end
        check_port(osc_ctrl_o, m_ctrl);
        check_read(`ADDR_CTRL_LO, m_ctrl);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        fails++;
        end_of_test();
    end

    initial begin
        logic [15:0] v;
        for (int g = 0; g < 4; g++) begin
            do_reset(g[1:0]);
            check_port(osc_group_o, g);
            check_read(`ADDR_SELECT_CFG, g);
            check_read(`ADDR_TUNE_SEQ, 0);
            check_read(`ADDR_TRIM_VALUE, 0);
            check_read(8'h30, 0);
        end
        $display("test reset and group done");
        for (int n = 0; n < 3; n++) begin
            v = rnd();
            m_tseq = v;
            wr(`ADDR_TUNE_SEQ, v);
            v = rnd();
            m_base = v & 15;
            wr(`ADDR_BASE_TRIM, v & 16'h000f);
            v = rnd() | 16'h8000;
            m_trim = v & 'h7fff;
            wr(`ADDR_TRIM_VALUE, v);
            // Read straight after the write, so the readback check fires
            check_read(`ADDR_TRIM_VALUE, m_trim);
            check_port(trim_value_o, m_trim);
            check_read(`ADDR_TUNE_SEQ, m_tseq);
            check_read(`ADDR_BASE_TRIM, m_base);
            for (int r = 0; r < 8; r++) begin
                @(posedge sys_clk_i);
                pwm_roll_i <= r[2:0];
                @(posedge sys_clk_i);
                #1;
                check_port(frc_trim_o, exp_trim(r));
            end
        end
        $display("test trim path done");
        // Open cycle shows in status; the window closes after that one cycle with no write
        wr(`ADDR_CTRL_LO, {8'h00, `KEY_LO_FIRST});
        wr(`ADDR_CTRL_LO, {8'h00, `KEY_LO_SECOND});
        check_read(`ADDR_STATUS, 'h10 | exp_trim(7));
        check_read(`ADDR_CTRL_LO, m_ctrl);
        v = rnd();
        unlock(1'b0, `KEY_LO_FIRST, `KEY_LO_SECOND, 0, 0, v[7:0]);
        unlock(1'b1, `KEY_HI_FIRST, `KEY_HI_SECOND, 0, 0, v[15:8]);
        unlock(1'b0, `KEY_LO_FIRST, `KEY_LO_SECOND, 1, 0, ~v[7:0]);
        unlock(1'b0, `KEY_LO_FIRST, `KEY_LO_SECOND, 0, 1, ~v[7:0]);
        unlock(1'b1, `KEY_HI_FIRST, `KEY_HI_SECOND, 1, 0, ~v[15:8]);
        unlock(1'b1, `KEY_HI_FIRST, `KEY_HI_SECOND, 0, 1, ~v[15:8]);
        unlock(1'b0, `KEY_HI_FIRST, `KEY_LO_SECOND, 0, 0, ~v[7:0]);
        unlock(1'b1, `KEY_HI_FIRST, `KEY_LO_SECOND, 0, 0, ~v[15:8]);
        unlock(1'b0, `KEY_LO_FIRST, `KEY_LO_SECOND, 0, 0, ~v[7:0]);
        unlock(1'b1, `KEY_HI_FIRST, `KEY_HI_SECOND, 0, 0, ~v[15:8]);
        $display("test unlock guard done");
        end_of_test();
    end
endmodule
